// ### rtl/can_signal_mapper_pkg.sv
// Package for the CAN signal mapper: map, field layouts, types, timing.
// Assumes a 125 MHz system clock and an AXI4-Lite register master.
package can_signal_mapper_pkg;
	// ****************************************
	// Counts and timing
	// ****************************************
	localparam int NUM_TX_SIG = 4;
	localparam int NUM_RX = 5;
	localparam int NUM_DTC = 5;
	localparam int NUM_KONST = 13;
	localparam int NUM_SRC_TYPES = 19;
	localparam int NUM_SRC_IDX = 15;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_PERIOD_NS = 1_000_000;
	localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DTC_HOLD_S = 3;
	localparam logic [11:0] DTC_HOLD_MS = 12'(DTC_HOLD_S * 1000);
	// ****************************************
	// Register map (region codes of upper address bits, payload byte addresses)
	// ****************************************
	localparam logic [5:0] TX_REGION = 6'h01, DTC_REGION = 6'h08, KONST_REGION = 6'h0A;
	localparam logic [3:0] RX_REGION = 4'h1;
	localparam logic [11:0] PAYLOAD_LO_ADDR = 12'h300, PAYLOAD_HI_ADDR = 12'h304;
	// Field positions inside register words
	localparam int SEL_IDX_LSB = 8, SEL_DTYPE_LSB = 16, SEL_WIDTH_LSB = 24;
	localparam int POS_BIT_LSB = 4, SCALE_OFFS_LSB = 16, RANGE_MAX_LSB = 16;
	localparam int CFG_DTYPE_LSB = 1, CFG_WIDTH_LSB = 8, CFG_BYTE_LSB = 16;
	localparam int CFG_BIT_LSB = 20, CFG_SENDER_LSB = 24, DTC_FMI_LSB = 24;
	// ****************************************
	// Protocol values and encodings
	// ****************************************
	localparam logic [7:0] GLOBAL_ADDR = 8'hFF;
	localparam logic [7:0] PDU2_MIN_PF = 8'hF0;
	localparam logic [17:0] DM1_PGN = 18'h0_FECA;
	localparam logic [1:0] DT_UNDEF = 2'h0, DT_DISCRETE = 2'h1, DT_CONT = 2'h2;
	localparam logic [4:0] ST_NONE = 5'h00, ST_RX = 5'h01, ST_KONST = 5'h07;
	localparam logic [4:0] ST_DTC = 5'h0A, ST_RX_TMO = 5'h0F;
	localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
	// Reset values
	localparam logic [5:0] TX_WIDTH_RST = 6'h08;
	localparam logic [15:0] RES_RST = 16'h0001;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [0:0] {WR_COLLECT = 1'b0, WR_RESP = 1'b1} wr_state_type;
	typedef struct packed {
		logic [4:0] src_type;
		logic [3:0] src_idx;
		logic [1:0] dtype;
		logic [5:0] width;
		logic [2:0] byte_idx;
		logic [2:0] bit_idx;
		logic [15:0] res;
		logic [15:0] offs;
		logic [15:0] tx_max;
	} tx_sig_type;
	typedef struct packed {
		logic enable;
		logic [1:0] dtype;
		logic [5:0] width;
		logic [2:0] byte_idx;
		logic [2:0] bit_idx;
		logic [7:0] sender;
		logic [17:0] pgn;
		logic [15:0] res;
		logic [15:0] offs;
		logic [15:0] min;
		logic [15:0] max;
		logic [15:0] timeout;
		logic [15:0] ms_count;
		logic [15:0] value;
		logic digital;
		logic fault;
	} rx_slot_type;
	typedef struct packed {
		logic [18:0] spn;
		logic [4:0] fmi;
		logic [11:0] ms_count;
		logic state;
	} dtc_type;
	typedef struct packed {
		logic valid;
		logic [17:0] pgn;
		logic [7:0] src_addr;
		logic [63:0] data;
	} rx_frame_type;
	typedef logic [NUM_SRC_TYPES-1:0][NUM_SRC_IDX-1:0][15:0] src_bank_type;
endpackage

// ### rtl/can_signal_mapper.sv
// CAN signal mapper: packs four sourced signals into one transmit payload,
// unpacks five receive slots, latches DM1 trouble codes, AXI4-Lite setup.
// Assumes frames arrive already decoded and synchronous to ref_clk_in.
// Overview of operation
// - Four signals, each source type and index
// - Source type zero disables the signal
// - Data type 0 undefined, 1 discrete, 2 continuous
// - Discrete: zero while source below transmit maximum
// - Undefined: all field bits driven to one
// - Width sets field bit count, at most 32
// - Byte index picks LSB payload byte
// - Bit index picks LSB bit in byte
// - Transmit: subtract offset, divide by resolution
// - Receive slots reset disabled, output nothing
// - Enabled slot faults without frame before timeout
// - Zero timeout never raises a fault
// - Sender 0xFF accepts destination-format frames from anyone
// - Specific sender rejects other source addresses in destination-format frames
// - Receive extraction mirrors transmit packing settings
// - Receive min/max give range and thresholds
// - Five receive slots, source type 1, 1-5
// - DM1 with matching SPN/FMI sets entry on
// - Entry off after 3 s without repeat
// - Selector decodes types 0-18, bounded indices
// - Reception-timeout source not selectable by signals
// - Analog to digital with min/max hysteresis
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module can_signal_mapper
	import can_signal_mapper_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES
)(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic [11:0] axi_awaddr_in,
	input wire logic axi_awvalid_in,
	output logic axi_awready_out,
	input wire logic [31:0] axi_wdata_in,
	input wire logic [3:0] axi_wstrb_in,
	input wire logic axi_wvalid_in,
	output logic axi_wready_out,
	output logic [1:0] axi_bresp_out,
	output logic axi_bvalid_out,
	input wire logic axi_bready_in,
	input wire logic [11:0] axi_araddr_in,
	input wire logic axi_arvalid_in,
	output logic axi_arready_out,
	output logic [31:0] axi_rdata_out,
	output logic [1:0] axi_rresp_out,
	output logic axi_rvalid_out,
	input wire logic axi_rready_in,
	input wire rx_frame_type rx_frame_in,
	input wire src_bank_type block_value_in,
	output logic [63:0] tx_payload_out,
	output logic [NUM_RX-1:0][15:0] rx_value_out,
	output logic [NUM_RX-1:0] rx_digital_out,
	output logic [NUM_RX-1:0] rx_fault_out,
	output logic [NUM_DTC-1:0] dtc_state_out
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		wr_state_type wr;
		logic aw_held;
		logic w_held;
		logic [11:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [16:0] tick_cnt;
		tx_sig_type [NUM_TX_SIG-1:0] tx;
		rx_slot_type [NUM_RX-1:0] rx;
		dtc_type [NUM_DTC-1:0] dtc;
		logic [NUM_KONST-1:0][15:0] konst;
		logic [63:0] tx_payload;
	} state_type;
	state_type s_q, s_d;
	logic [NUM_TX_SIG-1:0][15:0] tx_src; // Selected source per signal
	logic tick; // One-millisecond strobe
	logic dm1_hit; // Incoming frame is a DM1
	// Highest legal index per source type
	function automatic logic [3:0] max_index(input logic [4:0] t);
		case (t)
			5'd1, 5'd10: max_index = 4'd5;
			5'd2: max_index = 4'd4;
			5'd4: max_index = 4'd8;
			5'd6, 5'd16: max_index = 4'd6;
			5'd7: max_index = 4'd15;
			5'd13, 5'd14, 5'd15: max_index = 4'd1;
			5'd3, 5'd5, 5'd8, 5'd9, 5'd11, 5'd12, 5'd17, 5'd18: max_index = 4'd2;
			default: max_index = 4'd0;
		endcase
	endfunction
	// Source selector shared by all signals
	function automatic logic [15:0] pick(input state_type s, input src_bank_type b,
		input logic [4:0] t, input logic [3:0] i);
		pick = '0;
		if (t != ST_NONE && t != ST_RX_TMO && i != 4'd0 && i <= max_index(t))
		begin
			case (t)
				ST_RX: pick = s.rx[i-4'd1].value;
				ST_KONST: pick = (i < 4'd3) ? 16'(i - 4'd1) : s.konst[i-4'd3];
				ST_DTC: pick = {15'h0000, s.dtc[i-4'd1].state & (s.dtc[i-4'd1].spn != '0)};
				default: pick = b[t][i-4'd1];
			endcase
		end
	endfunction
	// Mask of the low w bits, at most 32 bits
	function automatic logic [63:0] low_mask(input logic [5:0] w);
		low_mask = (w >= 6'd32) ? 64'h0000_0000_FFFF_FFFF : ((64'h1 << w) - 64'h1);
	endfunction
	// Byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] st);
		for (int k = 0; k < 4; k++)
		begin
			merge[k*8 +: 8] = st[k] ? n[k*8 +: 8] : o[k*8 +: 8];
		end
	endfunction
	// Register read decode: {hit, data}
	function automatic logic [32:0] reg_read(input state_type s, input logic [11:0] a);
		tx_sig_type t;
		rx_slot_type r;
		dtc_type e;
		t = s.tx[a[5:4]];
		r = s.rx[a[7:5]];
		e = s.dtc[a[5:3]];
		reg_read = '0;
		if (a[11:6] == TX_REGION)
		begin
			reg_read[32] = 1'b1;
			case (a[3:2])
				2'd0: reg_read[31:0] = {2'b00, t.width, 6'h00, t.dtype, 4'h0, t.src_idx,
					3'b000, t.src_type};
				2'd1: reg_read[31:0] = {25'h0, t.bit_idx, 1'b0, t.byte_idx};
				2'd2: reg_read[31:0] = {t.offs, t.res};
				default: reg_read[31:0] = {16'h0000, t.tx_max};
			endcase
		end
		else if (a[11:8] == RX_REGION && a[7:5] < 3'(NUM_RX) && a[4:2] < 3'd7)
		begin
			reg_read[32] = 1'b1;
			case (a[4:2])
				3'd0: reg_read[31:0] = {r.sender, 1'b0, r.bit_idx, 1'b0, r.byte_idx, 2'b00,
					r.width, 5'h00, r.dtype, r.enable};
				3'd1: reg_read[31:0] = {14'h0000, r.pgn};
				3'd2: reg_read[31:0] = {r.offs, r.res};
				3'd3: reg_read[31:0] = {r.max, r.min};
				3'd4: reg_read[31:0] = {16'h0000, r.timeout};
				3'd5: reg_read[31:0] = {16'h0000, r.value};
				default: reg_read[31:0] = {30'h0, r.digital, r.fault};
			endcase
		end
		else if (a[11:6] == DTC_REGION && a[5:3] < 3'(NUM_DTC))
		begin
			reg_read[32] = 1'b1;
			reg_read[31:0] = a[2] ? {31'h0, e.state} : {3'b000, e.fmi, 5'h00, e.spn};
		end
		else if (a[11:6] == KONST_REGION && a[5:2] < 4'(NUM_KONST))
		begin
			reg_read = {1'b1, 16'h0000, s.konst[a[5:2]]};
		end
		else if (a == PAYLOAD_LO_ADDR || a == PAYLOAD_HI_ADDR)
		begin
			reg_read = {1'b1, a[2] ? s.tx_payload[63:32] : s.tx_payload[31:0]};
		end
		reg_read[1:0] = (a[1:0] == 2'b00) ? reg_read[1:0] : reg_read[1:0];
	endfunction
	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		logic aw_fire, w_fire, have_aw, have_w, pdu1, match;
		logic [11:0] a;
		logic [31:0] d;
		logic [32:0] rd;
		logic [63:0] fld, raw;
		logic [31:0] prod;
		logic [15:0] diff;
		logic [5:0] sh;
		aw_fire = 1'b0;
		w_fire = 1'b0;
		have_aw = 1'b0;
		have_w = 1'b0;
		pdu1 = 1'b0;
		match = 1'b0;
		a = '0;
		d = '0;
		rd = '0;
		fld = '0;
		raw = '0;
		prod = '0;
		diff = '0;
		sh = '0;
		s_d = s_q;
		tx_src = '0;
		// Millisecond prescaler
		tick = (s_q.tick_cnt == 17'(MS_TICK_CYCLES - 1));
		s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 17'd1;
		// Write channel: address and data in either order
		if (s_q.wr == WR_COLLECT)
		begin
			aw_fire = axi_awvalid_in && !s_q.aw_held;
			w_fire = axi_wvalid_in && !s_q.w_held;
			if (aw_fire)
			begin
				s_d.aw_held = 1'b1;
				s_d.waddr = axi_awaddr_in;
			end
			if (w_fire)
			begin
				s_d.w_held = 1'b1;
				s_d.wdata = axi_wdata_in;
				s_d.wstrb = axi_wstrb_in;
			end
			have_aw = s_d.aw_held;
			have_w = s_d.w_held;
			if (have_aw && have_w)
			begin
				a = {s_d.waddr[11:2], 2'b00};
				rd = reg_read(s_q, a);
				d = merge(rd[31:0], s_d.wdata, s_d.wstrb);
				s_d.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
				s_d.aw_held = 1'b0;
				s_d.w_held = 1'b0;
				s_d.wr = WR_RESP;
				if (a[11:6] == TX_REGION)
				begin
					case (a[3:2])
						2'd0:
						begin
							s_d.tx[a[5:4]].src_type = d[4:0];
							s_d.tx[a[5:4]].src_idx = d[SEL_IDX_LSB +: 4];
							s_d.tx[a[5:4]].dtype = d[SEL_DTYPE_LSB +: 2];
							s_d.tx[a[5:4]].width = d[SEL_WIDTH_LSB +: 6];
						end
						2'd1:
						begin
							s_d.tx[a[5:4]].byte_idx = d[2:0];
							s_d.tx[a[5:4]].bit_idx = d[POS_BIT_LSB +: 3];
						end
						2'd2:
						begin
							s_d.tx[a[5:4]].res = d[15:0];
							s_d.tx[a[5:4]].offs = d[SCALE_OFFS_LSB +: 16];
						end
						default: s_d.tx[a[5:4]].tx_max = d[15:0];
					endcase
				end
				else if (a[11:8] == RX_REGION && rd[32])
				begin
					case (a[4:2])
						3'd0:
						begin
							s_d.rx[a[7:5]].enable = d[0];
							s_d.rx[a[7:5]].dtype = d[CFG_DTYPE_LSB +: 2];
							s_d.rx[a[7:5]].width = d[CFG_WIDTH_LSB +: 6];
							s_d.rx[a[7:5]].byte_idx = d[CFG_BYTE_LSB +: 3];
							s_d.rx[a[7:5]].bit_idx = d[CFG_BIT_LSB +: 3];
							s_d.rx[a[7:5]].sender = d[CFG_SENDER_LSB +: 8];
						end
						3'd1: s_d.rx[a[7:5]].pgn = d[17:0];
						3'd2:
						begin
							s_d.rx[a[7:5]].res = d[15:0];
							s_d.rx[a[7:5]].offs = d[SCALE_OFFS_LSB +: 16];
						end
						3'd3:
						begin
							s_d.rx[a[7:5]].min = d[15:0];
							s_d.rx[a[7:5]].max = d[RANGE_MAX_LSB +: 16];
						end
						3'd4: s_d.rx[a[7:5]].timeout = d[15:0];
						default: ; // Value and status are read-only
					endcase
				end
				else if (a[11:6] == DTC_REGION && rd[32] && !a[2])
				begin
					s_d.dtc[a[5:3]].spn = d[18:0];
					s_d.dtc[a[5:3]].fmi = d[DTC_FMI_LSB +: 5];
				end
				else if (a[11:6] == KONST_REGION && rd[32])
				begin
					s_d.konst[a[5:2]] = d[15:0];
				end
			end
		end
		else if (axi_bready_in)
		begin
			s_d.wr = WR_COLLECT;
		end
		// Read channel: answer one cycle after address
		if (s_q.rvalid)
		begin
			s_d.rvalid = !axi_rready_in;
		end
		else if (axi_arvalid_in)
		begin
			rd = reg_read(s_q, {axi_araddr_in[11:2], 2'b00});
			s_d.rvalid = 1'b1;
			s_d.rdata = rd[31:0];
			s_d.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end
		// Transmit payload assembly
		s_d.tx_payload = '0;
		for (int i = 0; i < NUM_TX_SIG; i++)
		begin
			tx_src[i] = pick(s_q, block_value_in, s_q.tx[i].src_type, s_q.tx[i].src_idx);
			diff = (tx_src[i] > s_q.tx[i].offs) ? tx_src[i] - s_q.tx[i].offs : '0;
			case (s_q.tx[i].dtype)
				DT_UNDEF: fld = '1;
				DT_DISCRETE: fld = {63'h0, tx_src[i] >= s_q.tx[i].tx_max};
				default: fld = {48'h0, diff / ((s_q.tx[i].res == '0) ? 16'd1 : s_q.tx[i].res)};
			endcase
			sh = {s_q.tx[i].byte_idx, s_q.tx[i].bit_idx};
			if (s_q.tx[i].src_type != ST_NONE)
			begin
				s_d.tx_payload = s_d.tx_payload | ((fld & low_mask(s_q.tx[i].width)) << sh);
			end
		end
		// Receive slots
		pdu1 = rx_frame_in.pgn[15:8] < PDU2_MIN_PF;
		for (int i = 0; i < NUM_RX; i++)
		begin
			// Timeout count first, so a frame in the same cycle restarts it
			if (tick && s_q.rx[i].timeout != '0 && !s_q.rx[i].fault)
			begin
				s_d.rx[i].ms_count = s_q.rx[i].ms_count + 16'd1;
				s_d.rx[i].fault = (s_d.rx[i].ms_count >= s_q.rx[i].timeout);
			end
			match = s_q.rx[i].enable && rx_frame_in.valid && (pdu1
				? ({rx_frame_in.pgn[17:8], 8'h00} == {s_q.rx[i].pgn[17:8], 8'h00}
				&& (s_q.rx[i].sender == GLOBAL_ADDR
				|| s_q.rx[i].sender == rx_frame_in.src_addr))
				: rx_frame_in.pgn == s_q.rx[i].pgn);
			if (match)
			begin
				sh = {s_q.rx[i].byte_idx, s_q.rx[i].bit_idx};
				raw = (rx_frame_in.data >> sh) & low_mask(s_q.rx[i].width);
				prod = raw[31:0] * {16'h0000, s_q.rx[i].res};
				s_d.rx[i].value = (s_q.rx[i].dtype == DT_UNDEF) ? s_q.rx[i].value
					: prod[15:0] + s_q.rx[i].offs;
				s_d.rx[i].ms_count = '0;
				s_d.rx[i].fault = 1'b0;
			end
			// Digital view with hysteresis between min and max
			if (s_d.rx[i].value <= s_q.rx[i].min)
			begin
				s_d.rx[i].digital = 1'b0;
			end
			else if (s_d.rx[i].value >= s_q.rx[i].max)
			begin
				s_d.rx[i].digital = 1'b1;
			end
			if (!s_q.rx[i].enable || s_q.rx[i].timeout == '0)
			begin
				s_d.rx[i].fault = 1'b0;
				s_d.rx[i].ms_count = '0;
			end
			if (!s_q.rx[i].enable)
			begin
				s_d.rx[i].value = '0;
				s_d.rx[i].digital = 1'b0;
			end
		end
		// Trouble-code reactions
		dm1_hit = rx_frame_in.valid && rx_frame_in.pgn == DM1_PGN;
		for (int i = 0; i < NUM_DTC; i++)
		begin
			if (tick && s_q.dtc[i].state)
			begin
				s_d.dtc[i].ms_count = s_q.dtc[i].ms_count + 12'd1;
				if (s_d.dtc[i].ms_count >= DTC_HOLD_MS)
				begin
					s_d.dtc[i].state = 1'b0;
				end
			end
			if (dm1_hit && s_q.dtc[i].spn != '0
				&& {rx_frame_in.data[39:37], rx_frame_in.data[31:16]} == s_q.dtc[i].spn
				&& rx_frame_in.data[36:32] == s_q.dtc[i].fmi)
			begin
				s_d.dtc[i].state = 1'b1;
				s_d.dtc[i].ms_count = '0;
			end
		end
	end
	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			s_q <= '0;
			for (int i = 0; i < NUM_TX_SIG; i++)
			begin
				s_q.tx[i].dtype <= DT_CONT;
				s_q.tx[i].width <= TX_WIDTH_RST;
				s_q.tx[i].res <= RES_RST;
			end
			for (int i = 0; i < NUM_RX; i++)
			begin
				s_q.rx[i].res <= RES_RST;
			end
		end
		else
		begin
			s_q <= s_d;
		end
	end
	// Outputs
	assign axi_awready_out = (s_q.wr == WR_COLLECT) && !s_q.aw_held;
	assign axi_wready_out = (s_q.wr == WR_COLLECT) && !s_q.w_held;
	assign axi_bvalid_out = (s_q.wr == WR_RESP);
	assign axi_bresp_out = s_q.bresp;
	assign axi_arready_out = !s_q.rvalid;
	assign axi_rvalid_out = s_q.rvalid;
	assign axi_rdata_out = s_q.rdata;
	assign axi_rresp_out = s_q.rresp;
	assign tx_payload_out = s_q.tx_payload;
	always_comb
	begin
		for (int i = 0; i < NUM_RX; i++)
		begin
			rx_value_out[i] = s_q.rx[i].value;
			rx_digital_out[i] = s_q.rx[i].digital;
			rx_fault_out[i] = s_q.rx[i].fault;
		end
		for (int i = 0; i < NUM_DTC; i++)
		begin
			dtc_state_out[i] = s_q.dtc[i].state;
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	a_slot_disabled_quiet: assert property (!s_q.rx[0].enable |=>
		rx_value_out[0] == '0 && !rx_fault_out[0]) else $error("disabled slot active");
	a_zero_tmo_nofault: assert property (s_q.rx[0].timeout == '0 |=>
		!rx_fault_out[0]) else $error("fault with zero timeout");
	a_undef_all_ones: assert property (s_q.tx[1].src_type != ST_NONE
		&& s_q.tx[1].dtype == DT_UNDEF && s_q.tx[1].width == 6'd4
		&& s_q.tx[1].byte_idx == 3'd0 && s_q.tx[1].bit_idx == 3'd0
		|-> s_d.tx_payload[3:0] == 4'hF) else $error("undefined field not ones");
	a_disabled_sig_empty: assert property (s_q.tx[0].src_type == ST_NONE
		&& s_q.tx[1].src_type == ST_NONE && s_q.tx[2].src_type == ST_NONE
		&& s_q.tx[3].src_type == ST_NONE |=> tx_payload_out == '0)
		else $error("disabled signals in payload");
	a_discrete_low: assert property (s_q.tx[3].src_type != ST_NONE
		&& s_q.tx[3].dtype == DT_DISCRETE && s_q.tx[3].width == 6'd1
		&& tx_src[3] < s_q.tx[3].tx_max
		&& s_q.tx[3].byte_idx == 3'd7 && s_q.tx[3].bit_idx == 3'd7
		|-> !s_d.tx_payload[63]) else $error("discrete bit set below max");
	a_sender_reject: assert property (rx_frame_in.valid && s_q.rx[0].enable
		&& rx_frame_in.pgn[15:8] < PDU2_MIN_PF && s_q.rx[0].sender != GLOBAL_ADDR
		&& rx_frame_in.src_addr != s_q.rx[0].sender |=> $stable(rx_value_out[0]))
		else $error("frame from wrong sender taken");
	a_timeout_fault: assert property (s_q.rx[0].enable && s_q.rx[0].timeout != '0
		&& s_q.rx[0].ms_count == s_q.rx[0].timeout - 16'd1
		&& !s_q.rx[0].fault && tick && !rx_frame_in.valid |=> rx_fault_out[0])
		else $error("timeout missed");
	a_dtc_set: assert property (dm1_hit && s_q.dtc[0].spn != '0
		&& {rx_frame_in.data[39:37], rx_frame_in.data[31:16]} == s_q.dtc[0].spn
		&& rx_frame_in.data[36:32] == s_q.dtc[0].fmi |=> dtc_state_out[0])
		else $error("trouble code not latched");
	a_dtc_expire: assert property (s_q.dtc[0].state && tick && !dm1_hit
		&& s_q.dtc[0].ms_count == DTC_HOLD_MS - 12'd1 |=> !dtc_state_out[0])
		else $error("trouble code held past hold time");
	c_tx_write: cover property (axi_bvalid_out && axi_bready_in);
	c_rx_fault: cover property ($rose(rx_fault_out[0]));
	c_dtc_on: cover property ($rose(dtc_state_out[0]));
	c_digital_on: cover property ($rose(rx_digital_out[0]));
endmodule

// ### verification/can_ecu_model.sv
// Far-side ECU model: hands the mapper decoded frames one cycle wide.
// Assumes the mapper samples frames on the rising edge of ref_clk_in.
`timescale 1ns/1ps
module can_ecu_model
	import can_signal_mapper_pkg::*;
(
	input wire logic ref_clk_in,
	output rx_frame_type frame_out
);
	// ****
	// Frame driver
	// ****
	initial frame_out = '0;
	// One frame pulse, then an idle bus that no longer shows the last frame
	task send(input logic [17:0] pgn, input logic [7:0] sa, input logic [63:0] d);
	begin
		@(posedge ref_clk_in);
		frame_out <= '{1'b1, pgn, sa, d};
		@(posedge ref_clk_in);
		frame_out <= '{1'b0, ~pgn, ~sa, ~d};
	end
	endtask
endmodule

// ### verification/can_signal_mapper_tb_top.sv
// Bench for the signal mapper: register set-up over AXI4-Lite, frames in, payload out.
// Assumes the package and the ECU model are compiled first.
`timescale 1ns/1ps
module can_signal_mapper_tb_top
	import can_signal_mapper_pkg::*;
();
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rr;
	rx_frame_type frame;
	src_bank_type bank;
	logic [63:0] pay;
	logic [NUM_RX-1:0][15:0] rx_val;
	logic [NUM_RX-1:0] rx_dig, rx_flt;
	logic [NUM_DTC-1:0] dtc;
	int err_total, checks_done;
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	can_signal_mapper #(.MS_TICK_CYCLES(10)) i_dut (
		.ref_clk_in(clk),
		.reset_in(rst),
		.axi_awaddr_in(awaddr),
		.axi_awvalid_in(awvalid),
		.axi_awready_out(awready),
		.axi_wdata_in(wdata),
		.axi_wstrb_in(4'hF),
		.axi_wvalid_in(wvalid),
		.axi_wready_out(wready),
		.axi_bresp_out(bresp),
		.axi_bvalid_out(bvalid),
		.axi_bready_in(bready),
		.axi_araddr_in(araddr),
		.axi_arvalid_in(arvalid),
		.axi_arready_out(arready),
		.axi_rdata_out(rdata),
		.axi_rresp_out(rresp),
		.axi_rvalid_out(rvalid),
		.axi_rready_in(rready),
		.rx_frame_in(frame),
		.block_value_in(bank),
		.tx_payload_out(pay),
		.rx_value_out(rx_val),
		.rx_digital_out(rx_dig),
		.rx_fault_out(rx_flt),
		.dtc_state_out(dtc)
	);
	can_ecu_model i_ecu (
		.ref_clk_in(clk),
		.frame_out(frame)
	);
	// ****
	// Tasks
	// ****
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
	begin
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	end
	endtask
	// Write: address and data together, each released when taken
	task wr(input logic [11:0] a, input logic [31:0] d);
	begin
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		rr = bresp;
		#1;
	end
	endtask
	task rdw(input logic [11:0] a);
	begin
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		rd = rdata;
		rr = rresp;
		#1;
	end
	endtask
	task tick(input int n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask
	task finish_test;
	begin
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	// Watchdog
	initial
	begin
		repeat (60000) @(posedge clk);
		err_total++;
		finish_test;
	end
	// ****
	// Tests
	// ****
	initial
	begin
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata} = '0;
		bank = '0;
		err_total = 0;
		checks_done = 0;
		tick(20);
		rst <= 1'b0;
		tick(2);
		chk("payload", 0, pay);
		chk("rx values", 0, rx_val[3:0]);
		chk("rx flags", 0, {rx_val[4], rx_flt, rx_dig});
		rdw(12'h3F0);
		chk("unmapped", RESP_SLVERR, rr);
		wr(12'h3F0, 32'h0000_0000);
		chk("wr unmapped", RESP_SLVERR, rr);
		bank[2][0] <= 16'h0064;
		wr(12'h040, 32'h0802_0102);
		wr(12'h044, 32'h0000_0041);
		wr(12'h048, 32'h000A_0002);
		wr(12'h050, 32'h0400_0207);
		wr(12'h280, 32'h0000_0055);
		wr(12'h060, 32'h0802_0307);
		wr(12'h064, 32'h0000_0003);
		wr(12'h070, 32'h0101_0207);
		wr(12'h074, 32'h0000_0077);
		wr(12'h07C, 32'h0000_0001);
		chk("wr resp", RESP_OKAY, rr);
		tick(3);
		chk("payload", 64'h8000_0000_5502_D00F, pay);
		rdw(12'h304);
		chk("payload hi", 32'h8000_0000, rd);
		chk("rd resp", RESP_OKAY, rr);
		wr(12'h070, 32'h0101_0107);
		wr(12'h040, 32'h0802_0100);
		tick(3);
		chk("payload", 64'h0000_0000_5500_000F, pay);
		wr(12'h104, 32'h0000_EF00);
		wr(12'h108, 32'h0005_0003);
		wr(12'h10C, 32'h0040_0010);
		wr(12'h110, 32'h0000_0004);
		wr(12'h100, 32'h2202_0804);
		i_ecu.send(18'h0_EF00, 8'h22, 64'h0000_0000_0020_0000);
		tick(1);
		chk("rx off", 0, rx_val[0]);
		wr(12'h100, 32'h2202_0805);
		i_ecu.send(18'h0_EF00, 8'h33, 64'h0000_0000_0020_0000);
		tick(1);
		chk("rx other", 0, rx_val[0]);
		i_ecu.send(18'h0_EF00, 8'h22, 64'h0000_0000_0020_0000);
		tick(1);
		chk("rx val", 16'h0065, rx_val[0]);
		chk("rx on", 1, rx_dig[0]);
		i_ecu.send(18'h0_EF00, 8'h22, 64'h0000_0000_0008_0000);
		tick(1);
		chk("rx hold", 1, rx_dig[0]);
		i_ecu.send(18'h0_EF00, 8'h22, 64'h0000_0000_0003_0000);
		tick(1);
		chk("rx off", 0, rx_dig[0]);
		wr(12'h100, 32'hFF02_0805);
		i_ecu.send(18'h0_EF00, 8'h44, 64'h0000_0000_0010_0000);
		tick(1);
		chk("rx any", 16'h0035, rx_val[0]);
		tick(25);
		chk("fault early", 0, rx_flt[0]);
		tick(35);
		chk("fault", 1, rx_flt[0]);
		rdw(12'h114);
		chk("value reg", 32'h0000_0035, rd);
		wr(12'h110, 32'h0000_0000);
		i_ecu.send(18'h0_EF00, 8'h44, 64'h0000_0000_0010_0000);
		tick(100);
		chk("no tmo", 0, rx_flt[0]);
		wr(12'h040, 32'h0802_0101);
		tick(3);
		chk("rx src", 8'h15, pay[19:12]);
		wr(12'h200, 32'h0300_1234);
		i_ecu.send(DM1_PGN, 8'h55, 64'h0000_0003_1234_0000);
		tick(1);
		chk("dtc on", 1, dtc[0]);
		tick(29000);
		chk("dtc held", 1, dtc[0]);
		tick(1500);
		chk("dtc off", 0, dtc[0]);
		finish_test;
	end
endmodule
